// file: etp_pkg.sv
// Shared constants and carriers for the dual 8-bit PWM timer block.
// Assumes a single 25 MHz core clock and an APB register port.
package etp_pkg;

    localparam int DATA_W = 8;
    localparam int PRES_W = 10;
    localparam int CORE_CLK_HZ = 25000000;

    // Register byte offsets
    localparam logic [7:0] ADDR_A_CTRL = 8'h00;
    localparam logic [7:0] ADDR_A_COUNT = 8'h04;
    localparam logic [7:0] ADDR_A_CMP = 8'h08;
    localparam logic [7:0] ADDR_B_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_B_COUNT = 8'h10;
    localparam logic [7:0] ADDR_B_CMP = 8'h14;
    localparam logic [7:0] ADDR_ASYNC_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h20;

    // async_timer_status fields
    localparam int ST_CTRL_BUSY = 0;
    localparam int ST_CMP_BUSY = 1;
    localparam int ST_CNT_BUSY = 2;
    localparam int ST_ASYNC_SEL = 3;

    // Interrupt enable / flag fields
    localparam int IRQ_A_OVF = 0;
    localparam int IRQ_A_CMP = 1;
    localparam int IRQ_B_OVF = 2;
    localparam int IRQ_B_CMP = 3;
    localparam int IRQ_GLOBAL = 7;

    // Reset values
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;

    // Counter limits and timing
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam int PWM_PERIOD_TICKS = 2 * int'(COUNT_TOP);
    localparam logic [1:0] OSC_LATCH_EDGES = 2'h2;
    localparam int FLAG_SYNC_CYCLES = 3;

    typedef enum logic [1:0] {
        OUT_OFF = 2'b00,
        OUT_TOGGLE = 2'b01,
        OUT_CLEAR = 2'b10,
        OUT_SET = 2'b11
    } etp_cmode_e;

    // Control register, bit 7 reserved and reads zero
    typedef struct packed {
        logic pwmEn;
        etp_cmode_e cmpMode;
        logic clrOnMatch;
        logic [2:0] clkSel;
    } etp_ctrl_s;

    localparam etp_ctrl_s RST_CTRL = '{pwmEn: 1'b0, cmpMode: OUT_OFF, clrOnMatch: 1'b0, clkSel: 3'h0};

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmpRead;
        logic pin;
        logic pinEn;
        logic ovfPulse;
        logic cmpPulse;
    } etp_chan_s;

endpackage : etp_pkg

// file: etp_pwm_channel.sv
// One 8-bit timer channel: normal or phase-correct PWM counting, compare buffer, pin logic.
// Assumes tick is a one-cycle enable and loads are single-cycle pulses.
`timescale 1ns/1ns
module etp_pwm_channel
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tick,
    input etp_pkg::etp_ctrl_s ctrl,
    input wire logic countLoad,
    input wire logic [7:0] countData,
    input wire logic cmpLoad,
    input wire logic [7:0] cmpData,
    input wire logic matchBlock,
    output etp_pkg::etp_chan_s chan
);

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] activeCmp;
        logic [7:0] bufCmp;
        logic countDown;
        logic pin;
        logic ovf;
        logic cmpHit;
    } etp_chan_state_s;

    etp_chan_state_s state_reg;
    etp_chan_state_s state_next;

    always_comb
    begin
        logic match;
        match = 1'b0;
        state_next = state_reg;
        state_next.ovf = 1'b0;
        state_next.cmpHit = 1'b0;
        if (tick)
        begin
            // No match while a compare or count write is in flight
            match = (state_reg.count == state_reg.activeCmp) && !matchBlock;
            state_next.cmpHit = match;
            if (ctrl.pwmEn)
            begin
                if (state_reg.count == etp_pkg::COUNT_BOTTOM)
                begin
                    state_next.countDown = 1'b0;
                    state_next.count = state_reg.count + 8'h01;
                    state_next.ovf = 1'b1;
                end
                else if (state_reg.count == etp_pkg::COUNT_TOP)
                begin
                    state_next.countDown = 1'b1;
                    state_next.count = state_reg.count - 8'h01;
                    state_next.activeCmp = state_reg.bufCmp;
                end
                else if (state_reg.countDown)
                begin
                    state_next.count = state_reg.count - 8'h01;
                end
                else
                begin
                    state_next.count = state_reg.count + 8'h01;
                end
                if (match && ctrl.cmpMode == etp_pkg::OUT_CLEAR)
                begin
                    state_next.pin = state_reg.countDown;
                end
                else if (match && ctrl.cmpMode == etp_pkg::OUT_SET)
                begin
                    state_next.pin = !state_reg.countDown;
                end
            end
            else
            begin
                state_next.countDown = 1'b0;
                state_next.count = state_reg.count + 8'h01;
                state_next.ovf = (state_reg.count == etp_pkg::COUNT_TOP);
                if (match && ctrl.clrOnMatch)
                begin
                    state_next.count = etp_pkg::COUNT_BOTTOM;
                end
                if (match)
                begin
                    case (ctrl.cmpMode)
                        etp_pkg::OUT_TOGGLE: state_next.pin = !state_reg.pin;
                        etp_pkg::OUT_CLEAR: state_next.pin = 1'b0;
                        etp_pkg::OUT_SET: state_next.pin = 1'b1;
                        default: state_next.pin = state_reg.pin;
                    endcase
                end
            end
        end
        // Written count wins over the tick; counting resumes next tick
        if (countLoad)
        begin
            state_next.count = countData;
        end
        if (cmpLoad)
        begin
            state_next.bufCmp = cmpData;
            if (!ctrl.pwmEn)
            begin
                state_next.activeCmp = cmpData;
            end
        end
        // Extreme compare values pin the output at once
        if (ctrl.pwmEn && ctrl.cmpMode[1])
        begin
            if (state_next.activeCmp == etp_pkg::COUNT_BOTTOM)
            begin
                state_next.pin = (ctrl.cmpMode == etp_pkg::OUT_SET);
            end
            else if (state_next.activeCmp == etp_pkg::COUNT_TOP)
            begin
                state_next.pin = (ctrl.cmpMode == etp_pkg::OUT_CLEAR);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= '{count: etp_pkg::RST_COUNT, activeCmp: etp_pkg::RST_CMP, bufCmp: etp_pkg::RST_CMP,
                           countDown: 1'b0, pin: 1'b0, ovf: 1'b0, cmpHit: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_comb
    begin
        chan.count = state_reg.count;
        chan.cmpRead = state_reg.bufCmp;
        chan.pin = state_reg.pin;
        // Toggle mode has no meaning in PWM, so the pin is released there
        chan.pinEn = (ctrl.cmpMode != etp_pkg::OUT_OFF) && !(ctrl.pwmEn && ctrl.cmpMode == etp_pkg::OUT_TOGGLE);
        chan.ovfPulse = state_reg.ovf;
        chan.cmpPulse = state_reg.cmpHit;
    end

endmodule : etp_pwm_channel

// file: etp_timer_top.sv
// Two 8-bit PWM timers behind an APB slave; timer A may count the oscillator pin edges.
// Assumes APB signals and all pins are synchronous to core_clk.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module etp_timer_top
#(
    parameter int ADDR_W = 8
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic asyncOscClockPin,
    input wire logic timerBExtClock,
    output logic pwmOutputPinA,
    output logic pwmOutputPinAEn,
    output logic pwmOutputPinB,
    output logic pwmOutputPinBEn,
    output logic timerAIrq,
    output logic timerBIrq,
    output logic wakeRequest
);

    if (ADDR_W < 8)
    begin : g_bad_addr_w
        $error("ADDR_W must hold the register map");
    end

    localparam int HOLD_CTRL = 0;
    localparam int HOLD_CMP = 1;
    localparam int HOLD_CNT = 2;

    typedef struct packed {
        etp_pkg::etp_ctrl_s ctrlA;
        etp_pkg::etp_ctrl_s ctrlB;
        logic [2:0][7:0] hold;
        logic [2:0] busy;
        logic [2:0][1:0] edges;
        logic asyncSel;
        logic [7:0] irqEn;
        logic [3:0] flags;
        logic [etp_pkg::PRES_W-1:0] presA;
        logic [etp_pkg::PRES_W-1:0] presB;
        logic oscPrev;
        logic extPrev;
        logic [etp_pkg::FLAG_SYNC_CYCLES-1:0] syncOvf;
        logic [etp_pkg::FLAG_SYNC_CYCLES-1:0] syncCmp;
        logic wakePend;
        logic wakeArm;
        logic wakeReq;
        logic [31:0] rdata;
        logic err;
    } etp_top_s;

    etp_top_s state_reg;
    etp_top_s state_next;

    etp_pkg::etp_chan_s chanA;
    etp_pkg::etp_chan_s chanB;
    logic oscRise;
    logic extRise;
    logic extFall;
    logic tickA;
    logic tickB;
    logic apbWrite;
    logic apbSetup;
    logic loadCntA;
    logic loadCmpA;
    logic [7:0] cntDataA;
    logic [7:0] cmpDataA;
    logic loadCntB;
    logic loadCmpB;
    logic [2:0] transfer;

    // Divider tap: all selected low bits of the prescaler at ones
    function automatic logic divTick(input logic [etp_pkg::PRES_W-1:0] pres, input logic [2:0] sel,
                                     input logic isA);
        logic [etp_pkg::PRES_W-1:0] mask;
        mask = '0;
        case (sel)
            3'h2: mask = 10'h007;
            3'h3: mask = isA ? 10'h01F : 10'h03F;
            3'h4: mask = isA ? 10'h03F : 10'h0FF;
            3'h5: mask = isA ? 10'h07F : 10'h3FF;
            3'h6: mask = 10'h0FF;
            3'h7: mask = 10'h3FF;
            default: mask = '0;
        endcase
        divTick = (sel != 3'h0) && ((pres & mask) == mask);
    endfunction : divTick

    always_comb
    begin
        logic srcA;
        srcA = 1'b0;
        oscRise = asyncOscClockPin && !state_reg.oscPrev;
        extRise = timerBExtClock && !state_reg.extPrev;
        extFall = !timerBExtClock && state_reg.extPrev;
        apbSetup = psel && !penable;
        apbWrite = psel && penable && pwrite;
        // In async mode timer A advances only on oscillator edges
        srcA = state_reg.asyncSel ? oscRise : 1'b1;
        tickA = srcA && divTick(state_reg.presA, state_reg.ctrlA.clkSel, 1'b1);
        if (state_reg.ctrlB.clkSel == 3'h6)
        begin
            tickB = extFall;
        end
        else if (state_reg.ctrlB.clkSel == 3'h7)
        begin
            tickB = extRise;
        end
        else
        begin
            tickB = divTick(state_reg.presB, state_reg.ctrlB.clkSel, 1'b0);
        end
        for (int i = 0; i < 3; i++)
        begin
            transfer[i] = state_reg.busy[i] && oscRise && (state_reg.edges[i] == etp_pkg::OSC_LATCH_EDGES - 2'h1);
        end
        if (state_reg.asyncSel)
        begin
            loadCntA = transfer[HOLD_CNT];
            cntDataA = state_reg.hold[HOLD_CNT];
            loadCmpA = transfer[HOLD_CMP];
            cmpDataA = state_reg.hold[HOLD_CMP];
        end
        else
        begin
            loadCntA = apbWrite && paddr[7:0] == etp_pkg::ADDR_A_COUNT;
            cntDataA = pwdata[7:0];
            loadCmpA = apbWrite && paddr[7:0] == etp_pkg::ADDR_A_CMP;
            cmpDataA = pwdata[7:0];
        end
        loadCntB = apbWrite && paddr[7:0] == etp_pkg::ADDR_B_COUNT;
        loadCmpB = apbWrite && paddr[7:0] == etp_pkg::ADDR_B_CMP;
    end

    etp_pwm_channel u_chan_a
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tickA),
        .ctrl(state_reg.ctrlA),
        .countLoad(loadCntA),
        .countData(cntDataA),
        .cmpLoad(loadCmpA),
        .cmpData(cmpDataA),
        .matchBlock(state_reg.asyncSel && (state_reg.busy[HOLD_CMP] || state_reg.busy[HOLD_CNT])),
        .chan(chanA)
    );

    etp_pwm_channel u_chan_b
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tickB),
        .ctrl(state_reg.ctrlB),
        .countLoad(loadCntB),
        .countData(pwdata[7:0]),
        .cmpLoad(loadCmpB),
        .cmpData(pwdata[7:0]),
        .matchBlock(1'b0),
        .chan(chanB)
    );

    always_comb
    begin
        logic [3:0] setFlags;
        logic [3:0] clrFlags;
        logic [7:0] rd;
        logic hit;
        setFlags = '0;
        clrFlags = '0;
        rd = '0;
        hit = 1'b1;
        state_next = state_reg;
        state_next.oscPrev = asyncOscClockPin;
        state_next.extPrev = timerBExtClock;
        state_next.wakeReq = 1'b0;
        if (state_reg.asyncSel ? oscRise : 1'b1)
        begin
            state_next.presA = state_reg.presA + 10'h001;
        end
        state_next.presB = state_reg.presB + 10'h001;

        // Holding registers: each has its own busy bit and edge count
        for (int i = 0; i < 3; i++)
        begin
            if (transfer[i])
            begin
                state_next.busy[i] = 1'b0;
                state_next.edges[i] = 2'h0;
            end
            else if (state_reg.busy[i] && oscRise)
            begin
                state_next.edges[i] = state_reg.edges[i] + 2'h1;
            end
        end
        if (transfer[HOLD_CTRL])
        begin
            state_next.ctrlA = etp_pkg::etp_ctrl_s'(state_reg.hold[HOLD_CTRL][6:0]);
        end

        // Flags from timer A cross a three-stage pipe in async mode
        state_next.syncOvf = {state_reg.syncOvf[etp_pkg::FLAG_SYNC_CYCLES-2:0], chanA.ovfPulse};
        state_next.syncCmp = {state_reg.syncCmp[etp_pkg::FLAG_SYNC_CYCLES-2:0], chanA.cmpPulse};
        if (state_reg.asyncSel)
        begin
            setFlags[etp_pkg::IRQ_A_OVF] = state_reg.syncOvf[etp_pkg::FLAG_SYNC_CYCLES-1];
            setFlags[etp_pkg::IRQ_A_CMP] = state_reg.syncCmp[etp_pkg::FLAG_SYNC_CYCLES-1];
        end
        else
        begin
            setFlags[etp_pkg::IRQ_A_OVF] = chanA.ovfPulse;
            setFlags[etp_pkg::IRQ_A_CMP] = chanA.cmpPulse;
        end
        setFlags[etp_pkg::IRQ_B_OVF] = chanB.ovfPulse;
        setFlags[etp_pkg::IRQ_B_CMP] = chanB.cmpPulse;

        // Wake waits for the next oscillator rise, then stays disarmed until one more oscillator rise has passed
        if (state_reg.asyncSel && (chanA.ovfPulse || chanA.cmpPulse))
        begin
            state_next.wakePend = 1'b1;
        end
        if (oscRise)
        begin
            state_next.wakeArm = 1'b1;
            if (state_reg.wakePend && state_reg.wakeArm)
            begin
                state_next.wakeReq = 1'b1;
                state_next.wakePend = 1'b0;
                state_next.wakeArm = 1'b0;
            end
        end

        // APB write, taken in the access phase
        if (apbWrite)
        begin
            if (paddr[7:0] == etp_pkg::ADDR_A_CTRL)
            begin
                if (state_reg.asyncSel)
                begin
                    state_next.hold[HOLD_CTRL] = pwdata[7:0];
                    state_next.busy[HOLD_CTRL] = 1'b1;
                    state_next.edges[HOLD_CTRL] = 2'h0;
                end
                else
                begin
                    state_next.ctrlA = etp_pkg::etp_ctrl_s'(pwdata[6:0]);
                end
            end
            else if (paddr[7:0] == etp_pkg::ADDR_A_COUNT && state_reg.asyncSel)
            begin
                state_next.hold[HOLD_CNT] = pwdata[7:0];
                state_next.busy[HOLD_CNT] = 1'b1;
                state_next.edges[HOLD_CNT] = 2'h0;
            end
            else if (paddr[7:0] == etp_pkg::ADDR_A_CMP && state_reg.asyncSel)
            begin
                state_next.hold[HOLD_CMP] = pwdata[7:0];
                state_next.busy[HOLD_CMP] = 1'b1;
                state_next.edges[HOLD_CMP] = 2'h0;
            end
            else if (paddr[7:0] == etp_pkg::ADDR_B_CTRL)
            begin
                state_next.ctrlB = etp_pkg::etp_ctrl_s'(pwdata[6:0]);
            end
            else if (paddr[7:0] == etp_pkg::ADDR_ASYNC_STATUS)
            begin
                state_next.asyncSel = pwdata[etp_pkg::ST_ASYNC_SEL];
            end
            else if (paddr[7:0] == etp_pkg::ADDR_IRQ_ENABLE)
            begin
                state_next.irqEn = pwdata[7:0];
            end
            else if (paddr[7:0] == etp_pkg::ADDR_IRQ_FLAGS)
            begin
                clrFlags = pwdata[3:0];
            end
        end
        // A flag set in the clearing cycle survives
        state_next.flags = (state_reg.flags & ~clrFlags) | setFlags;

        // APB read data is captured in the setup phase
        if (paddr[7:0] == etp_pkg::ADDR_A_CTRL)
        begin
            rd = {1'b0, state_reg.asyncSel ? state_reg.hold[HOLD_CTRL][6:0] : state_reg.ctrlA};
        end
        else if (paddr[7:0] == etp_pkg::ADDR_A_COUNT)
        begin
            rd = chanA.count;
        end
        else if (paddr[7:0] == etp_pkg::ADDR_A_CMP)
        begin
            rd = state_reg.asyncSel ? state_reg.hold[HOLD_CMP] : chanA.cmpRead;
        end
        else if (paddr[7:0] == etp_pkg::ADDR_B_CTRL)
        begin
            rd = {1'b0, state_reg.ctrlB};
        end
        else if (paddr[7:0] == etp_pkg::ADDR_B_COUNT)
        begin
            rd = chanB.count;
        end
        else if (paddr[7:0] == etp_pkg::ADDR_B_CMP)
        begin
            rd = chanB.cmpRead;
        end
        else if (paddr[7:0] == etp_pkg::ADDR_ASYNC_STATUS)
        begin
            rd = {4'h0, state_reg.asyncSel, state_reg.busy};
        end
        else if (paddr[7:0] == etp_pkg::ADDR_IRQ_ENABLE)
        begin
            rd = state_reg.irqEn;
        end
        else if (paddr[7:0] == etp_pkg::ADDR_IRQ_FLAGS)
        begin
            rd = {4'h0, state_reg.flags};
        end
        else
        begin
            hit = 1'b0;
        end
        if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:0] > ADDR_W'(etp_pkg::ADDR_IRQ_FLAGS))
        begin
            hit = 1'b0;
        end
        if (apbSetup)
        begin
            state_next.rdata = {24'h000000, hit ? rd : 8'h00};
            state_next.err = !hit;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= '{ctrlA: etp_pkg::RST_CTRL, ctrlB: etp_pkg::RST_CTRL, hold: '0, busy: 3'h0, edges: '0,
                           asyncSel: 1'b0, irqEn: etp_pkg::RST_IRQ_ENABLE, flags: 4'h0, presA: '0, presB: '0,
                           oscPrev: 1'b0, extPrev: 1'b0, syncOvf: '0, syncCmp: '0, wakePend: 1'b0,
                           wakeArm: 1'b1, wakeReq: 1'b0, rdata: 32'h00000000, err: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_comb
    begin
        prdata = state_reg.rdata;
        pready = psel && penable;
        pslverr = psel && penable && state_reg.err;
        pwmOutputPinA = chanA.pin;
        pwmOutputPinAEn = chanA.pinEn;
        pwmOutputPinB = chanB.pin;
        pwmOutputPinBEn = chanB.pinEn;
        timerAIrq = state_reg.irqEn[etp_pkg::IRQ_GLOBAL] && |(state_reg.flags[1:0] & state_reg.irqEn[1:0]);
        timerBIrq = state_reg.irqEn[etp_pkg::IRQ_GLOBAL] && |(state_reg.flags[3:2] & state_reg.irqEn[3:2]);
        wakeRequest = state_reg.wakeReq;
    end

endmodule : etp_timer_top

// file: etp_timer_chk.sv
// Port checker for the dual PWM timer block.
// Assumes it is bound to etp_timer_top with the default 8-bit address.
`timescale 1ns/1ns
module etp_timer_chk
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwmOutputPinBEn,
    input wire logic timerAIrq,
    input wire logic timerBIrq,
    input wire logic wakeRequest
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_rdy; pready == (psel && penable); endproperty
    a_rdy: assert property (p_rdy) else $error("ready not tied to access phase");
    property p_errPh; pslverr |-> psel && penable; endproperty
    a_errPh: assert property (p_errPh) else $error("error outside access phase");
    property p_errMap; psel && penable && paddr > 8'h20 |-> pslverr; endproperty
    a_errMap: assert property (p_errMap) else $error("unmapped access not refused");
    property p_rdHi; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_rdHi: assert property (p_rdHi) else $error("read data upper bits set");
    property p_wake; wakeRequest |=> !wakeRequest; endproperty
    a_wake: assert property (p_wake) else $error("wake not a single pulse");
    // Flags are sticky, so an interrupt can only drop after a register write
    property p_irqA; $fell(timerAIrq) |-> $past(psel && penable && pwrite); endproperty
    a_irqA: assert property (p_irqA) else $error("timer A irq fell without write");
    property p_irqB; $fell(timerBIrq) |-> $past(psel && penable && pwrite); endproperty
    a_irqB: assert property (p_irqB) else $error("timer B irq fell without write");
    property p_enB; $changed(pwmOutputPinBEn) |-> $past(psel && penable && pwrite); endproperty
    a_enB: assert property (p_enB) else $error("pin enable moved without write");
    c_wake: cover property (wakeRequest);
    c_err: cover property (pslverr);
    c_irqB: cover property (timerBIrq);
endmodule : etp_timer_chk

bind etp_timer_top etp_timer_chk u_etp_timer_chk (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .pwmOutputPinBEn, .timerAIrq, .timerBIrq, .wakeRequest);

// file: etp_osc_model.sv
// Watch-crystal model feeding the asynchronous timer pin.
// Assumes core clock edges fall on even times; its period is deliberately unrelated.
`timescale 1ns/1ns
module etp_osc_model
(
    output logic osc
);
    // Core clock edges all fall on even times; an odd start keeps every toggle off them
    initial
    begin
        osc = 1'b0;
        #5;
        forever #318 osc = ~osc;
    end
endmodule : etp_osc_model

// file: tb_top.sv
// Self-checking bench for the dual PWM timer over APB.
// Assumes the checker and the oscillator model are compiled first.
`timescale 1ns/1ns
module tb_top;
    logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, osc, pinB, enB, irqB, enA, irqA, wake;
    int wakes = 0;
    int err_count = 0;
    int samples_checked = 0;
    int c;
    etp_osc_model u_etp_osc_model (.osc(osc));
    etp_timer_top u_etp_timer_top (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .asyncOscClockPin(osc), .timerBExtClock(1'b0), .pwmOutputPinA(), .pwmOutputPinAEn(enA),
        .pwmOutputPinB(pinB), .pwmOutputPinBEn(enB), .timerAIrq(irqA), .timerBIrq(irqB), .wakeRequest(wake));
    initial forever #20 core_clk = ~core_clk;
    // Wake is a one-cycle pulse, so it is counted at every edge rather than polled
    always @(posedge core_clk)
        if (wake === 1'b1)
            wakes++;
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic tick(input int lim);
        @(posedge core_clk);
        c++;
        if (c >= lim)
        begin
            err_count++;
            stop_test();
        end
    endtask : tick
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        c = 0;
        tick(20);
        while (pready !== 1'b1) tick(20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic waitRise;
        c = 0;
        while (pinB !== 1'b0) tick(1200);
        while (pinB !== 1'b1) tick(1200);
    endtask : waitRise
    task automatic sc_regs;
        apb(0, etp_pkg::ADDR_A_CMP, 0);
        chk("aCmpReset", 32'h0, rd);
        apb(0, 8'h24, 0);
        chk("badAddrErr", 1, err);
        apb(1, etp_pkg::ADDR_B_CTRL, 32'hFF);
        apb(0, etp_pkg::ADDR_B_CTRL, 0);
        chk("bCtrlReserved", 32'h7F, rd);
    endtask : sc_regs
    task automatic sc_pwm;
        apb(1, etp_pkg::ADDR_B_CTRL, 32'h60);
        apb(1, etp_pkg::ADDR_B_CMP, 32'h40);
        apb(0, etp_pkg::ADDR_B_CMP, 0);
        chk("bCmpBuffered", 32'h40, rd);
        apb(1, etp_pkg::ADDR_IRQ_ENABLE, 32'h84);
        apb(1, etp_pkg::ADDR_B_CTRL, 32'h61);
        // Pin only rises once the buffered compare reaches the active side
        waitRise();
        waitRise();
        chk("pwmPeriod", etp_pkg::PWM_PERIOD_TICKS, c);
        apb(0, etp_pkg::ADDR_IRQ_FLAGS, 0);
        chk("bOvfFlag", 1, rd[etp_pkg::IRQ_B_OVF]);
        chk("bIrqOn", 1, irqB);
        apb(1, etp_pkg::ADDR_IRQ_FLAGS, 32'h04);
        chk("bIrqCleared", 0, irqB);
        apb(1, etp_pkg::ADDR_IRQ_ENABLE, 32'h80);
        repeat (600) @(posedge core_clk);
        chk("bIrqMasked", 0, irqB);
    endtask : sc_pwm
    task automatic sc_force;
        for (int i = 0; i < 4; i++)
        begin
            apb(1, etp_pkg::ADDR_B_CTRL, i[1] ? 32'h71 : 32'h61);
            apb(1, etp_pkg::ADDR_B_CMP, i[0] ? 32'hFF : 32'h00);
            repeat (600) @(posedge core_clk);
            chk("forcedPin", i[0] ^ i[1], pinB);
            chk("pinEnable", 1, enB);
        end
        apb(1, etp_pkg::ADDR_B_CTRL, 32'h51);
        chk("modeOneOff", 0, enB);
    endtask : sc_force
    task automatic sc_async;
        apb(1, etp_pkg::ADDR_IRQ_ENABLE, 0);
        apb(1, etp_pkg::ADDR_ASYNC_STATUS, 32'h08);
        apb(1, etp_pkg::ADDR_A_CTRL, 32'h41);
        apb(1, etp_pkg::ADDR_A_COUNT, 32'h00);
        apb(1, etp_pkg::ADDR_A_CMP, 32'h33);
        apb(0, etp_pkg::ADDR_ASYNC_STATUS, 0);
        chk("allBusy", 32'h0F, rd);
        apb(0, etp_pkg::ADDR_A_CMP, 0);
        chk("cmpHeld", 32'h33, rd);
        // Each busy bit is left to clear before any rewrite
        repeat (80) @(posedge core_clk);
        apb(0, etp_pkg::ADDR_ASYNC_STATUS, 0);
        chk("busyCleared", 32'h08, rd);
        apb(0, etp_pkg::ADDR_A_CTRL, 0);
        chk("ctrlHeld", 32'h41, rd);
        chk("aPinOff", 0, enA);
        chk("wakeSeen", 1, wakes != 0);
        // First overflow has crossed the flag pipe long before this; the next is a full period away
        apb(1, etp_pkg::ADDR_IRQ_ENABLE, 32'h81);
        chk("aIrqOn", 1, irqA);
        apb(1, etp_pkg::ADDR_IRQ_FLAGS, 32'h01);
        chk("aIrqCleared", 0, irqA);
    endtask : sc_async
    initial
    begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        sc_regs();
        sc_pwm();
        sc_force();
        sc_async();
        stop_test();
    end
endmodule : tb_top
